// *** dv/brake_coil_model.sv ***
// Model of the brake relay and the motion controller.
`timescale 1ns/1ps
module brake_coil_model (
    // Clock.
    input wire logic clk_sys,
    // Run request and brake output.
    input wire logic run_req,
    input wire logic brake_release_out,
    // Servo pin and coil state.
    output logic servo_enable_in,
    output logic coil_locked
);
    // The controller works the enable pin only, never the brake itself.
    initial servo_enable_in = 1'b0;
    always @(posedge clk_sys) begin
        servo_enable_in <= run_req;
    end
    // An unpowered coil holds the shaft locked.
    assign coil_locked = !brake_release_out;
endmodule : brake_coil_model

// *** dv/holding_brake_sequencer_checker.sv ***
// Port assertions for the holding brake sequencer.
`timescale 1ns/1ps
module brake_seq_checker
    import brake_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Servo pin and drive outputs.
    input wire logic servo_enable_in,
    input wire logic brake_release_out,
    input wire logic motor_drive_en,
    input wire logic [3:0] control_mode_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A restart write on the bus.
    logic restart_wr;
    assign restart_wr = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == OFS_RESTART);
    // A request that the slave takes.
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // A read taken at one address.
    sequence s_rd(logic [7:0] a);
        s_take ##0 (!wb_we_i && wb_adr_i == a);
    endsequence
    a_ack_follows_take: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (s_rd(8'h24) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_version_fixed: assert property (s_rd(OFS_VERSION) |=> wb_dat_o[15:0] == VERSION_VAL)
        else $error("version read wrong");
    a_release_servo_on: assert property ($rose(brake_release_out) |->
        $past(servo_enable_in, 2) && motor_drive_en)
        else $error("brake released without servo on");
    a_engage_servo_off: assert property ($fell(brake_release_out) |->
        !$past(servo_enable_in, 2))
        else $error("brake engaged while servo on");
    a_mode_on_restart: assert property ($changed(control_mode_select) |->
        $past(restart_wr) || $past(restart_wr, 2) || $past(restart_wr, 3))
        else $error("mode changed without restart");
endmodule : brake_seq_checker

bind holding_brake_sequencer brake_seq_checker #(.TICK_DIV(TICK_DIV)) i_chk (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .servo_enable_in(servo_enable_in),
    .brake_release_out(brake_release_out), .motor_drive_en(motor_drive_en),
    .control_mode_select(control_mode_select));

// *** dv/test_holding_brake_sequencer.sv ***
// Self-checking bench for the holding brake sequencer.
`timescale 1ns/1ps
module test_holding_brake_sequencer
    import brake_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] rd;
    logic run_req = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, brake_release_out, motor_drive_en, servo_enable_in, coil_locked;
    logic [3:0] control_mode_select;
    int err_total = 0;
    int comparisons = 0;
    int n, m;
    // 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;
    holding_brake_sequencer #(.TICK_DIV(10)) i_dut (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .servo_enable_in(servo_enable_in), .brake_release_out(brake_release_out),
        .motor_drive_en(motor_drive_en), .control_mode_select(control_mode_select));
    brake_coil_model i_coil (.clk_sys(clk_sys), .run_req(run_req),
        .brake_release_out(brake_release_out), .servo_enable_in(servo_enable_in),
        .coil_locked(coil_locked));
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Compares a cycle count with a window.
    task automatic rng(input string nm, input int lo, input int hi, input int v);
        comparisons++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : rng
    // One classic Wishbone cycle; read data lands in rd.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1);
        rng("ack wait", 1, 19, k);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    // Counts cycles until brake or drive output shows a level.
    task automatic wait_out(input logic drv, input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge clk_sys);
            c++;
        end while (((drv ? motor_drive_en : brake_release_out) !== lvl) && c < 300);
    endtask : wait_out
    task automatic t_reset;
        xfer(1'b0, OFS_ON_DELAY, 32'h0);
        chk("on delay", 32'h64, {16'h0, rd[15:0]});
        xfer(1'b0, OFS_OFF_DELAY, 32'h0);
        chk("off delay", 32'h64, {16'h0, rd[15:0]});
        sel <= 4'h2;
        xfer(1'b1, OFS_ON_DELAY, 32'h0000_1200);
        sel <= 4'hf;
        xfer(1'b0, OFS_ON_DELAY, 32'h0);
        chk("byte lane", 32'h1264, {16'h0, rd[15:0]});
        chk("coil idle", 32'h1, {31'h0, coil_locked});
    endtask : t_reset
    task automatic t_normal;
        xfer(1'b1, OFS_ON_DELAY, 32'h3);
        xfer(1'b1, OFS_OFF_DELAY, 32'h2);
        run_req <= 1'b1;
        wait_out(1'b0, 1'b1, n);
        rng("on delay", 30, 46, n);
        chk("drive on", 32'h1, {31'h0, motor_drive_en});
        run_req <= 1'b0;
        wait_out(1'b1, 1'b0, n);
        rng("drive off", 1, 6, n);
        chk("brake held", 32'h1, {31'h0, brake_release_out});
        wait_out(1'b0, 1'b0, m);
        rng("off delay", 20, 46, n + m);
        chk("coil locked", 32'h1, {31'h0, coil_locked});
    endtask : t_normal
    task automatic t_alt;
        xfer(1'b1, OFS_SEQ_CFG, 32'h1);
        run_req <= 1'b1;
        wait_out(1'b0, 1'b1, n);
        xfer(1'b1, OFS_SEQ_CFG, 32'h0);
        xfer(1'b0, OFS_FAULT, 32'h0);
        chk("fault lock", 32'h1, {24'h0, rd[7:0]});
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk("reject", 32'h1, {31'h0, rd[3]});
        xfer(1'b0, OFS_SEQ_CFG, 32'h0);
        chk("seq kept", 32'h1, {31'h0, rd[0]});
        run_req <= 1'b0;
        wait_out(1'b0, 1'b0, n);
        rng("alt brake", 1, 6, n);
        chk("alt drive", 32'h1, {31'h0, motor_drive_en});
        wait_out(1'b1, 1'b0, m);
        rng("alt delay", 20, 46, n + m);
        xfer(1'b1, OFS_SEQ_CFG, 32'h0);
        xfer(1'b0, OFS_SEQ_CFG, 32'h0);
        chk("seq off", 32'h0, {31'h0, rd[0]});
    endtask : t_alt
    task automatic t_ro;
        xfer(1'b1, OFS_VERSION, 32'h1234);
        xfer(1'b0, OFS_FAULT, 32'h0);
        chk("fault ro", 32'h2, {24'h0, rd[7:0]});
        xfer(1'b0, OFS_VERSION, 32'h0);
        chk("version", {16'h0, VERSION_VAL}, {16'h0, rd[15:0]});
        xfer(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask : t_ro
    task automatic t_restart;
        xfer(1'b1, OFS_CTRL_MODE, 32'h5);
        xfer(1'b0, OFS_CTRL_ACTIVE, 32'h0);
        chk("mode held", 32'h0, {28'h0, rd[3:0]});
        xfer(1'b1, OFS_RESTART, {16'h0, RESTART_KEY});
        xfer(1'b0, OFS_CTRL_ACTIVE, 32'h0);
        chk("mode applied", 32'h5, {28'h0, control_mode_select});
    endtask : t_restart
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // Main sequence after two reset cycles.
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_normal;
        t_alt;
        t_ro;
        t_restart;
        wrap_up;
    end
    // Watchdog well past the expected run length.
    initial begin
        #200000;
        err_total++;
        wrap_up;
    end
endmodule : test_holding_brake_sequencer

// *** hw/brake_pkg.sv ***
// Package with register map, reset values and timing constants of the brake sequencer.
package brake_pkg;
    // ------------------------------------------------------------------
    // Clock and tick timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // ------------------------------------------------------------------
    // Register word offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ON_DELAY = 8'h00;
    localparam logic [7:0] OFS_OFF_DELAY = 8'h04;
    localparam logic [7:0] OFS_CTRL_MODE = 8'h08;
    localparam logic [7:0] OFS_CTRL_ACTIVE = 8'h0c;
    localparam logic [7:0] OFS_SEQ_CFG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_VERSION = 8'h18;
    localparam logic [7:0] OFS_FAULT = 8'h1c;
    localparam logic [7:0] OFS_RESTART = 8'h20;
    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] ON_DELAY_RST = 16'h0064;
    localparam logic [15:0] OFF_DELAY_RST = 16'h0064;
    localparam logic [3:0] CTRL_MODE_RST = 4'h0;
    localparam int STS_BRAKE_BIT = 0;
    localparam int STS_DRIVE_BIT = 1;
    localparam int STS_SERVO_BIT = 2;
    localparam int STS_REJECT_BIT = 3;
    localparam int STS_PEND_BIT = 4;
    // Version value is arbitrary.
    localparam logic [15:0] VERSION_VAL = 16'h0101;
    // Fault codes produced internally.
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_LOCKED_WR = 8'h01;
    localparam logic [7:0] FAULT_RO_WR = 8'h02;
    // Key written to the restart register to apply pending values.
    localparam logic [15:0] RESTART_KEY = 16'h5a5a;
endpackage : brake_pkg

// *** hw/holding_brake_sequencer.sv ***
// Holding brake sequencer with delay parameters on a Wishbone slave.
`timescale 1ns/1ps
// Contract
// - Inactive release output means brake engaged.
// - Active release output means brake released.
// - Servo off: drop brake after off-delay.
// - Alternate: drop brake, drive off later.
// - On-delay in ms, reset value 100.
// - Off-delay in ms, reset value 100.
// - Enable-locked writes refused while servo enabled.
// - Read-only parameters ignore writes.
// - Restart-class values apply after restart.
// - Engage brake only after servo off.
module holding_brake_sequencer
    import brake_pkg::*;
#(
    parameter int DW = 16,
    parameter int TICK_DIV = TICK_CYCLES
) (
    // System clock and synchronous reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Servo enable pin from outside.
    input wire logic servo_enable_in,
    // Brake relay output and motor drive enable.
    output logic brake_release_out,
    output logic motor_drive_en,
    // Control mode in effect.
    output logic [3:0] control_mode_select
);
    // ------------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------------
    // Sequencer phases.
    // S_OFF holds the brake closed and the drive off until the servo enable
    // arrives through the synchroniser. S_ON_WAIT runs the drive with the brake
    // still closed while the on-delay counts. S_ON has both open. S_OFF_WAIT
    // counts the off-delay after the enable drops; which output falls first
    // depends on the sequence choice held in alt_seq.
    typedef enum logic [2:0] {
        S_OFF,
        S_ON_WAIT,
        S_ON,
        S_OFF_WAIT
    } seq_t;

    // All registered state of this block.
    // The enable pin is asynchronous, so it passes sync1 and sync2 before any
    // logic looks at it; en_prev is the last synchronised value and marks edges.
    // The delay settings reset to their defaults; mode_pend holds a written
    // control mode until a restart copies it into mode_act.
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic en_prev;
        seq_t seq;
        logic [DW-1:0] cnt;
        logic [DW-1:0] on_delay;
        logic [DW-1:0] off_delay;
        logic [3:0] mode_pend;
        logic [3:0] mode_act;
        logic alt_seq;
        logic brake;
        logic drive;
        logic reject;
        logic [7:0] fault;
        logic [31:0] rdata;
        logic ack;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    // Millisecond tick from the divider.
    // The divider runs freely from reset, so the first tick after an enable
    // change can come anywhere within one tick period.
    ms_tick_if tk_if ();

    ms_tick_gen #(
        .CYCLES(TICK_DIV)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tk(tk_if.src)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Merge write data into a word with byte enables.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // A delay is complete once the count has passed the setting. The count is
    // cleared at the enable change and the first tick lands up to one tick later,
    // so one extra tick makes sure the full setting has elapsed.
    // A saturated count also ends the delay, so the largest setting cannot hang.
    function automatic logic delay_done(input logic [DW-1:0] cnt,
            input logic [DW-1:0] lim);
        return (cnt > lim) || (&cnt);
    endfunction : delay_done

    // Combined signals.
    logic req;
    logic wr;
    logic servo_on;
    logic edge_seen;
    logic [31:0] merged;
    logic [31:0] status_word;

    // A request is taken only while no acknowledge is out, so a held strobe
    // is not answered twice.
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    // Write direction of a taken request.
    assign wr = req && wb_we_i;
    // Synchronised servo enable.
    assign servo_on = st_ff.sync2;
    // High for one cycle after each synchronised enable change.
    assign edge_seen = st_ff.sync2 != st_ff.en_prev;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // One process computes every next value: synchroniser, delay counter,
    // sequencer and the bus registers.
    always_comb begin
        nxt_st = st_ff;
        merged = 32'h0;
        status_word = 32'h0;
        // Two-flop synchroniser on the enable pin.
        nxt_st.sync1 = servo_enable_in;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.en_prev = st_ff.sync2;
        nxt_st.ack = 1'b0;

        // Millisecond counter, cleared on each enable change.
        // The count saturates instead of wrapping so a long wait never restarts.
        if (edge_seen) begin
            nxt_st.cnt = '0;
        end else if (tk_if.tick && st_ff.cnt != '1) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end

        // Sequencer.
        case (st_ff.seq)
            S_OFF: begin
                // Brake engaged and motor locked.
                nxt_st.brake = 1'b0;
                nxt_st.drive = 1'b0;
                if (servo_on) begin
                    nxt_st.seq = S_ON_WAIT;
                    nxt_st.drive = 1'b1;
                end
            end
            S_ON_WAIT: begin
                // Release brake once the on-delay passes.
                if (!servo_on) begin
                    // Enable lost before release: back to the braked state.
                    nxt_st.seq = S_OFF;
                    nxt_st.drive = 1'b0;
                end else if (!edge_seen && delay_done(st_ff.cnt, st_ff.on_delay)) begin
                    nxt_st.seq = S_ON;
                    nxt_st.brake = 1'b1;
                end
            end
            S_ON: begin
                // Both open; leave once the synchronised enable drops.
                if (!servo_on) begin
                    nxt_st.seq = S_OFF_WAIT;
                    if (st_ff.alt_seq) begin
                        // Alternate order: brake first, drive later.
                        nxt_st.brake = 1'b0;
                    end
                end
            end
            S_OFF_WAIT: begin
                if (servo_on) begin
                    // Servo back during the off-delay: drive on again at once.
                    nxt_st.drive = 1'b1;
                    if (st_ff.brake) begin
                        // Brake still open: never close it under an enabled servo.
                        nxt_st.seq = S_ON;
                    end else begin
                        // Brake already closed: time a fresh on-delay.
                        nxt_st.seq = S_ON_WAIT;
                    end
                end else if (!edge_seen && delay_done(st_ff.cnt, st_ff.off_delay)) begin
                    // Off-delay elapsed: brake locks after servo off.
                    nxt_st.seq = S_OFF;
                    nxt_st.brake = 1'b0;
                    nxt_st.drive = 1'b0;
                end else if (!st_ff.alt_seq) begin
                    // Normal order keeps the brake open during the delay.
                    nxt_st.brake = 1'b1;
                    nxt_st.drive = 1'b0;
                end else begin
                    // Alternate order keeps the drive on with the brake closed.
                    nxt_st.brake = 1'b0;
                end
            end
            default: begin
                // Unused encodings fall back to the safe, braked state.
                nxt_st.seq = S_OFF;
            end
        endcase

        // Status word for readback.
        // Bit 4 shows a mode written but not yet applied by a restart.
        status_word[STS_BRAKE_BIT] = st_ff.brake;
        status_word[STS_DRIVE_BIT] = st_ff.drive;
        status_word[STS_SERVO_BIT] = servo_on;
        status_word[STS_REJECT_BIT] = st_ff.reject;
        status_word[STS_PEND_BIT] = st_ff.mode_pend != st_ff.mode_act;

        // Bus access: one-cycle registered acknowledge.
        // Read data is registered with the acknowledge; the ack stands one cycle, the data until the next request.
        if (req) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h0;
            case (wb_adr_i)
                OFS_ON_DELAY: begin
                    // Free parameter: byte lanes merge into the stored delay.
                    nxt_st.rdata = 32'(st_ff.on_delay);
                    merged = merge_bytes(32'(st_ff.on_delay), wb_dat_i, wb_sel_i);
                    if (wr) begin
                        nxt_st.on_delay = merged[DW-1:0];
                    end
                end
                OFS_OFF_DELAY: begin
                    // Free parameter: byte lanes merge into the stored delay.
                    nxt_st.rdata = 32'(st_ff.off_delay);
                    merged = merge_bytes(32'(st_ff.off_delay), wb_dat_i, wb_sel_i);
                    if (wr) begin
                        nxt_st.off_delay = merged[DW-1:0];
                    end
                end
                OFS_CTRL_MODE: begin
                    // Restart class: stored now, applied at restart.
                    nxt_st.rdata = {28'h0, st_ff.mode_pend};
                    if (wr && wb_sel_i[0]) begin
                        nxt_st.mode_pend = wb_dat_i[3:0];
                    end
                end
                OFS_CTRL_ACTIVE: begin
                    // Active mode is read-only; a write only logs a fault.
                    nxt_st.rdata = {28'h0, st_ff.mode_act};
                    if (wr) begin
                        nxt_st.fault = FAULT_RO_WR;
                    end
                end
                OFS_SEQ_CFG: begin
                    // Enable-locked: refused while the servo is on.
                    nxt_st.rdata = {31'h0, st_ff.alt_seq};
                    if (wr && servo_on) begin
                        nxt_st.reject = 1'b1;
                        nxt_st.fault = FAULT_LOCKED_WR;
                    end else if (wr && wb_sel_i[0]) begin
                        nxt_st.alt_seq = wb_dat_i[0];
                    end
                end
                OFS_STATUS: begin
                    nxt_st.rdata = status_word;
                    if (wr) begin
                        // Writing one clears the refusal flag.
                        if (wb_sel_i[0] && wb_dat_i[STS_REJECT_BIT]) begin
                            nxt_st.reject = 1'b0;
                        end
                    end
                end
                OFS_VERSION: begin
                    // Read-only: constant value, writes dropped.
                    nxt_st.rdata = {16'h0, VERSION_VAL};
                    if (wr) begin
                        nxt_st.fault = FAULT_RO_WR;
                    end
                end
                OFS_FAULT: begin
                    // Fault code is read-only; reading clears it.
                    nxt_st.rdata = {24'h0, st_ff.fault};
                    if (!wr) begin
                        nxt_st.fault = FAULT_NONE;
                    end
                end
                OFS_RESTART: begin
                    // Restart key applies the pending mode.
                    if (wr && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == RESTART_KEY) begin
                        nxt_st.mode_act = st_ff.mode_pend;
                    end
                end
                default: begin
                    // Unmapped: reads zero, writes ignored.
                    nxt_st.rdata = 32'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset loads constants only; both delays come back at 100 ms.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.seq <= S_OFF;
            st_ff.on_delay <= DW'(ON_DELAY_RST);
            st_ff.off_delay <= DW'(OFF_DELAY_RST);
            st_ff.mode_pend <= CTRL_MODE_RST;
            st_ff.mode_act <= CTRL_MODE_RST;
            st_ff.fault <= FAULT_NONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs come straight from the state flops, so they never glitch.
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    assign brake_release_out = st_ff.brake;
    assign motor_drive_en = st_ff.drive;
    assign control_mode_select = st_ff.mode_act;
endmodule : holding_brake_sequencer

// *** hw/ms_tick_gen.sv ***
// Millisecond enable divider running from the system clock.
`timescale 1ns/1ps
module ms_tick_gen
    import brake_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Tick output.
    ms_tick_if.src tk
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t st_ff;
    div_state_t nxt_st;

    // Count cycles and pulse once per period.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= 32'(CYCLES - 1)) begin
            nxt_st.cnt = 32'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
    end

    // Register the state.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick = st_ff.tick;
endmodule : ms_tick_gen

// *** hw/ms_tick_if.sv ***
// Interface carrying the millisecond tick between the divider and the sequencer.
`timescale 1ns/1ps
interface ms_tick_if;
    // One-cycle enable pulse once per millisecond.
    logic tick;
    // Divider output side.
    modport src (output tick);
    // Consumer side.
    modport dst (input tick);
endinterface : ms_tick_if
